// File: src/e1lc_path_ctrl.sv
// Control words and bit-level path selection for the E1 transceiver
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
module e1lc_path_ctrl (
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	input wire logic line_rx_pos_i,
	input wire logic line_rx_neg_i,
	output logic line_tx_pos_o,
	output logic line_tx_neg_o,
	input wire logic backplane_data_in_i,
	output logic backplane_data_out_o,
	output logic backplane_data_out_oe_o,
	output logic backplane_signalling_out_o,
	output logic backplane_signalling_out_oe_o,
	input wire logic framer_tx_bit_i,
	input wire logic framer_rx_bit_i,
	input wire logic framer_sig_bit_i,
	input wire e1lc_pkg::e1lc_status_s status_i,
	input wire logic ccs_mode_i,
	input wire logic crc4_compare_i,
	input wire logic [4:0] sa_bits_sel_i,
	input wire logic national_bit_link_controller_sel_irq_i,
	input wire logic slot16_link_controller_sel_irq_i,
	output logic bit_tick_o,
	output logic rx_line_bit_o,
	output logic national_bit_link_controller_sel_o,
	output logic [4:0] national_bit_sa_mask_o,
	output logic slot16_link_controller_sel_o,
	output logic national_bit_link_controller_sel_irq_o,
	output logic slot16_link_controller_sel_irq_o,
	output logic receive_transparent_o,
	output logic tx_ebit_o,
	output logic multiframe_reframe_o,
	output logic basic_frame_reframe_o,
	output logic recovered_frame_or_clock_out_o
);
	// ****************************************
	// Declarations
	// ****************************************
	logic [7:0] link_controller_select;
	logic [7:0] coding_loopback_control;
	logic [7:0] transmit_alarm_control;
	logic [e1lc_pkg::ACC_W-1:0] rate_acc;
	logic bit_tick;
	logic [e1lc_pkg::BIT_CNT_W-1:0] bit_cnt;
	logic [4:0] slot;
	logic bp_in_sync;
	e1lc_pkg::e1lc_pair_s rx_pins;
	e1lc_pkg::e1lc_pair_s rx_pair;
	e1lc_pkg::e1lc_pair_s enc_pair;
	logic [3:0] dec_line;
	logic last_pol;
	logic rx_dec_bit;
	logic tx_src_bit;
	logic tx_bit;
	logic prev_mf_reframe;
	logic prev_reframe;
	logic [7:0] next_rdata;

	function automatic logic is_mark(input e1lc_pkg::e1lc_pair_s p);
		is_mark = p.pos ^ p.neg;
	endfunction : is_mark

	function automatic logic in_slot(input logic [4:0] s, input logic [4:0] want);
		in_slot = (s == want);
	endfunction : in_slot

	// ****************************************
	// Control words
	// ****************************************
	// Store used bits only
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			link_controller_select <= e1lc_pkg::RST_LINK_CTRL_SEL;
			coding_loopback_control <= e1lc_pkg::RST_CODING_LOOP;
			transmit_alarm_control <= e1lc_pkg::RST_TX_ALARM;
		end else if (reg_wr_i) begin
			case (reg_addr_i)
				e1lc_pkg::OFF_LINK_CTRL_SEL: begin
					link_controller_select <= reg_wdata_i & e1lc_pkg::USED_LINK_CTRL_SEL;
				end
				e1lc_pkg::OFF_CODING_LOOP: begin
					coding_loopback_control <= reg_wdata_i & e1lc_pkg::USED_CODING_LOOP;
				end
				e1lc_pkg::OFF_TX_ALARM: begin
					transmit_alarm_control <= reg_wdata_i & e1lc_pkg::USED_TX_ALARM;
				end
				default: begin
				end
			endcase
		end
	end

	always_comb begin
		case (reg_addr_i)
			e1lc_pkg::OFF_LINK_CTRL_SEL: next_rdata = link_controller_select;
			e1lc_pkg::OFF_CODING_LOOP: next_rdata = coding_loopback_control;
			e1lc_pkg::OFF_TX_ALARM: next_rdata = transmit_alarm_control;
			default: next_rdata = e1lc_pkg::UNMAPPED_READ;
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_rd_i) begin
			reg_rdata_o <= next_rdata;
		end else begin
			reg_rdata_o <= 8'h00;
		end
	end

	// ****************************************
	// Bit timing
	// ****************************************
	// Fractional divider gives one tick per line bit
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			rate_acc <= '0;
			bit_tick <= 1'b0;
		end else if (rate_acc >= e1lc_pkg::ACC_W'(e1lc_pkg::CLK_KHZ - e1lc_pkg::LINE_KHZ)) begin
			rate_acc <= rate_acc - e1lc_pkg::ACC_W'(e1lc_pkg::CLK_KHZ - e1lc_pkg::LINE_KHZ);
			bit_tick <= 1'b1;
		end else begin
			rate_acc <= rate_acc + e1lc_pkg::ACC_W'(e1lc_pkg::LINE_KHZ);
			bit_tick <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			bit_cnt <= '0;
			bit_tick_o <= 1'b0;
		end else begin
			bit_tick_o <= bit_tick;
			if (bit_tick) begin
				bit_cnt <= bit_cnt + 8'h01;
			end
		end
	end

	assign slot = bit_cnt[7:3];

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			recovered_frame_or_clock_out_o <= 1'b0;
		end else if (transmit_alarm_control[e1lc_pkg::B_RATE64]) begin
			recovered_frame_or_clock_out_o <= bit_cnt[e1lc_pkg::RATE64_BIT];
		end else begin
			recovered_frame_or_clock_out_o <= bit_cnt[e1lc_pkg::RATE8_BIT];
		end
	end

	// ****************************************
	// Pin synchronisers
	// ****************************************
	e1lc_sync3 #(
		.WIDTH(3)
	) u_pin_sync (
		.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i),
		.async_i({line_rx_pos_i, line_rx_neg_i, backplane_data_in_i}),
		.sync_o({rx_pins.pos, rx_pins.neg, bp_in_sync})
	);

	// ****************************************
	// Receive path
	// ****************************************
	// Metallic loop source select
	assign rx_pair = coding_loopback_control[e1lc_pkg::B_METALLIC] ?
		e1lc_pkg::e1lc_pair_s'({line_tx_pos_o, line_tx_neg_o}) : rx_pins;

	// HDB3 decode, violation clears itself and the B three bits back
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			dec_line <= 4'h0;
			last_pol <= 1'b0;
		end else if (bit_tick) begin
			if (is_mark(rx_pair)) begin
				last_pol <= rx_pair.pos;
			end
			if (is_mark(rx_pair) && (rx_pair.pos == last_pol)) begin
				dec_line <= {1'b0, dec_line[1:0], 1'b0};
			end else begin
				dec_line <= {dec_line[2:0], is_mark(rx_pair)};
			end
		end
	end

	assign rx_dec_bit = dec_line[3];

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			rx_line_bit_o <= 1'b0;
		end else if (coding_loopback_control[e1lc_pkg::B_DIG_LOOP]) begin
			rx_line_bit_o <= tx_bit;
		end else begin
			rx_line_bit_o <= rx_dec_bit;
		end
	end

	// ****************************************
	// Transmit path
	// ****************************************
	// Payload loop except slot zero
	assign tx_src_bit = (coding_loopback_control[e1lc_pkg::B_PAY_LOOP] &&
		!in_slot(slot, e1lc_pkg::SLOT_ZERO)) ? rx_dec_bit : framer_tx_bit_i;

	assign tx_bit = tx_src_bit | transmit_alarm_control[e1lc_pkg::B_AIS] |
		(transmit_alarm_control[e1lc_pkg::B_AIS0] && in_slot(slot, e1lc_pkg::SLOT_ZERO)) |
		(transmit_alarm_control[e1lc_pkg::B_SLOT16_ALL_ONES_DETECTED] && in_slot(slot, e1lc_pkg::SLOT_SIXTEEN));

	e1lc_line_enc u_line_enc (
		.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i),
		.bit_tick_i(bit_tick),
		.bit_i(tx_bit),
		.ami_only_i(coding_loopback_control[e1lc_pkg::B_AMI]),
		.pair_o(enc_pair)
	);

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			line_tx_pos_o <= 1'b0;
			line_tx_neg_o <= 1'b0;
		end else if (coding_loopback_control[e1lc_pkg::B_REM_LOOP]) begin
			line_tx_pos_o <= rx_pins.pos;
			line_tx_neg_o <= rx_pins.neg;
		end else begin
			line_tx_pos_o <= enc_pair.pos;
			line_tx_neg_o <= enc_pair.neg;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			tx_ebit_o <= 1'b0;
		end else if (status_i.crc4_sync_lost) begin
			tx_ebit_o <= transmit_alarm_control[e1lc_pkg::B_EBIT];
		end else begin
			tx_ebit_o <= crc4_compare_i;
		end
	end

	// ****************************************
	// Backplane outputs
	// ****************************************
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			backplane_data_out_o <= 1'b0;
		end else if (coding_loopback_control[e1lc_pkg::B_BP_LOOP]) begin
			backplane_data_out_o <= bp_in_sync;
		end else if (link_controller_select[e1lc_pkg::B_RX_TRANSP]) begin
			backplane_data_out_o <= rx_line_bit_o;
		end else begin
			backplane_data_out_o <= framer_rx_bit_i;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			backplane_data_out_oe_o <= 1'b1;
		end else begin
			backplane_data_out_oe_o <= !(transmit_alarm_control[e1lc_pkg::B_DATA_GATE] &&
				(status_i.los || status_i.frame_sync_lost ||
				status_i.crc4_sync_lost || status_i.rx_ais));
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			backplane_signalling_out_o <= 1'b0;
			backplane_signalling_out_oe_o <= 1'b1;
		end else begin
			backplane_signalling_out_o <= framer_sig_bit_i;
			backplane_signalling_out_oe_o <= !(transmit_alarm_control[e1lc_pkg::B_SIG_GATE] &&
				(status_i.multiframe_sync_lost || status_i.slot16_all_ones_detected));
		end
	end

	// ****************************************
	// Link controllers
	// ****************************************
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			national_bit_link_controller_sel_o <= 1'b0;
			national_bit_sa_mask_o <= 5'h00;
			slot16_link_controller_sel_o <= 1'b0;
			receive_transparent_o <= 1'b0;
		end else begin
			national_bit_link_controller_sel_o <= link_controller_select[e1lc_pkg::B_NAT_SEL];
			national_bit_sa_mask_o <= link_controller_select[e1lc_pkg::B_NAT_SEL] ?
				sa_bits_sel_i : 5'h00;
			slot16_link_controller_sel_o <= link_controller_select[e1lc_pkg::B_S16_SEL] &&
				ccs_mode_i;
			receive_transparent_o <= link_controller_select[e1lc_pkg::B_RX_TRANSP];
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			national_bit_link_controller_sel_irq_o <= 1'b0;
			slot16_link_controller_sel_irq_o <= 1'b0;
		end else begin
			national_bit_link_controller_sel_irq_o <= national_bit_link_controller_sel_irq_i && link_controller_select[e1lc_pkg::B_NAT_SEL];
			slot16_link_controller_sel_irq_o <= slot16_link_controller_sel_irq_i && link_controller_select[e1lc_pkg::B_S16_SEL];
		end
	end

	// ****************************************
	// Reframe triggers
	// ****************************************
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			prev_mf_reframe <= 1'b0;
			prev_reframe <= 1'b0;
			multiframe_reframe_o <= 1'b0;
			basic_frame_reframe_o <= 1'b0;
		end else begin
			prev_mf_reframe <= coding_loopback_control[e1lc_pkg::B_MF_REFRAME];
			prev_reframe <= transmit_alarm_control[e1lc_pkg::B_REFRAME];
			multiframe_reframe_o <= prev_mf_reframe &&
				!coding_loopback_control[e1lc_pkg::B_MF_REFRAME];
			basic_frame_reframe_o <= prev_reframe &&
				!transmit_alarm_control[e1lc_pkg::B_REFRAME];
		end
	end
endmodule : e1lc_path_ctrl

// File: shared/e1lc_pkg.sv
// Constants and carrier types for the E1 link path control block
package e1lc_pkg;
	// ****************************************
	// Register port
	// ****************************************
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam logic [7:0] OFF_LINK_CTRL_SEL = 8'h14;
	localparam logic [7:0] OFF_CODING_LOOP = 8'h15;
	localparam logic [7:0] OFF_TX_ALARM = 8'h16;
	localparam logic [7:0] RST_LINK_CTRL_SEL = 8'h00;
	localparam logic [7:0] RST_CODING_LOOP = 8'h00;
	localparam logic [7:0] RST_TX_ALARM = 8'h00;
	localparam logic [7:0] USED_LINK_CTRL_SEL = 8'he0;
	localparam logic [7:0] USED_CODING_LOOP = 8'h7f;
	localparam logic [7:0] USED_TX_ALARM = 8'hff;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;
	// Link controller select word
	localparam int B_NAT_SEL = 7;
	localparam int B_S16_SEL = 6;
	localparam int B_RX_TRANSP = 5;
	// Coding and loopback word
	localparam int B_METALLIC = 6;
	localparam int B_AMI = 5;
	localparam int B_MF_REFRAME = 4;
	localparam int B_DIG_LOOP = 3;
	localparam int B_REM_LOOP = 2;
	localparam int B_BP_LOOP = 1;
	localparam int B_PAY_LOOP = 0;
	// Transmit alarm word
	localparam int B_AIS = 7;
	localparam int B_AIS0 = 6;
	localparam int B_SLOT16_ALL_ONES_DETECTED = 5;
	localparam int B_EBIT = 4;
	localparam int B_REFRAME = 3;
	localparam int B_RATE64 = 2;
	localparam int B_DATA_GATE = 1;
	localparam int B_SIG_GATE = 0;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_KHZ = 100000;
	localparam int LINE_KHZ = 2048;
	localparam int ACC_W = 17;
	localparam int BIT_CNT_W = 8;
	localparam logic [4:0] SLOT_ZERO = 5'h00;
	localparam logic [4:0] SLOT_SIXTEEN = 5'h10;
	localparam int RATE64_BIT = 4;
	localparam int RATE8_BIT = 7;
	localparam int SA_W = 5;
	// ****************************************
	// Types
	// ****************************************
	typedef struct packed {
		logic pos;
		logic neg;
	} e1lc_pair_s;
	typedef struct packed {
		logic los;
		logic frame_sync_lost;
		logic crc4_sync_lost;
		logic rx_ais;
		logic multiframe_sync_lost;
		logic slot16_all_ones_detected;
	} e1lc_status_s;
	typedef enum logic [3:0] {
		SYM_ZERO = 4'h1,
		SYM_MARK = 4'h2,
		SYM_BPOL = 4'h4,
		SYM_VIOL = 4'h8
	} e1lc_sym_e;
endpackage : e1lc_pkg

// File: src/e1lc_sync3.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module e1lc_sync3 #(
	parameter int WIDTH = 1
) (
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;

	// Output only follows once the second and third stages agree
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
			sync_o <= '0;
		end else begin
			stage1 <= async_i;
			stage2 <= stage1;
			stage3 <= stage2;
			sync_o <= (stage2 & stage3) | (sync_o & (stage2 ^ stage3));
		end
	end
endmodule : e1lc_sync3

// File: src/e1lc_line_enc.sv
// Transmit line encoder, HDB3 or plain AMI
`timescale 1ns/1ps
module e1lc_line_enc (
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic bit_tick_i,
	input wire logic bit_i,
	input wire logic ami_only_i,
	output e1lc_pkg::e1lc_pair_s pair_o
);
	e1lc_pkg::e1lc_sym_e sym [0:3];
	logic [1:0] zero_run;
	logic pulse_par;
	logic polarity;
	logic make_viol;

	assign make_viol = !ami_only_i && !bit_i && (zero_run == 2'h3);

	// Four-symbol look-ahead with substitution
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			for (int i = 0; i < 4; i++) begin
				sym[i] <= e1lc_pkg::SYM_ZERO;
			end
			zero_run <= 2'h0;
			pulse_par <= 1'b0;
		end else if (bit_tick_i) begin
			sym[0] <= bit_i ? e1lc_pkg::SYM_MARK : e1lc_pkg::SYM_ZERO;
			sym[1] <= sym[0];
			sym[2] <= sym[1];
			sym[3] <= sym[2];
			if (make_viol) begin
				sym[0] <= e1lc_pkg::SYM_VIOL;
				if (!pulse_par) begin
					sym[3] <= e1lc_pkg::SYM_BPOL;
				end
				zero_run <= 2'h0;
				pulse_par <= 1'b0;
			end else if (bit_i) begin
				zero_run <= 2'h0;
				pulse_par <= !pulse_par;
			end else begin
				zero_run <= zero_run + 2'h1;
			end
		end
	end

	// Alternate mark polarity, violations repeat the last one
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			polarity <= 1'b0;
			pair_o <= '0;
		end else if (bit_tick_i) begin
			case (sym[3])
				e1lc_pkg::SYM_MARK, e1lc_pkg::SYM_BPOL: begin
					polarity <= !polarity;
					pair_o <= {!polarity, polarity};
				end
				e1lc_pkg::SYM_VIOL: begin
					pair_o <= {polarity, !polarity};
				end
				default: begin
					pair_o <= '0;
				end
			endcase
		end
	end
endmodule : e1lc_line_enc

// File: testbench/e1lc_path_ctrl_asserts.sv
// Concurrent checks on the ports of the E1 link path control block
`timescale 1ns/1ps
module e1lc_path_ctrl_asserts (
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	input wire e1lc_pkg::e1lc_status_s status_i,
	input wire logic ccs_mode_i,
	input wire logic crc4_compare_i,
	input wire logic [4:0] sa_bits_sel_i,
	input wire logic national_bit_link_controller_sel_irq_i,
	input wire logic slot16_link_controller_sel_irq_i,
	input wire logic backplane_data_out_oe_o,
	input wire logic backplane_signalling_out_oe_o,
	input wire logic national_bit_link_controller_sel_o,
	input wire logic [4:0] national_bit_sa_mask_o,
	input wire logic slot16_link_controller_sel_o,
	input wire logic national_bit_link_controller_sel_irq_o,
	input wire logic slot16_link_controller_sel_irq_o,
	input wire logic receive_transparent_o,
	input wire logic tx_ebit_o,
	input wire logic multiframe_reframe_o,
	input wire logic basic_frame_reframe_o
);
	// ****************************************
	// Shadow copies of the control words
	// ****************************************
	logic [7:0] sh_sel;
	logic [7:0] sh_loop;
	logic [7:0] sh_alarm;
	logic [7:0] rd_exp;
	logic data_bad;
	logic sig_bad;
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			sh_sel <= e1lc_pkg::RST_LINK_CTRL_SEL;
			sh_loop <= e1lc_pkg::RST_CODING_LOOP;
			sh_alarm <= e1lc_pkg::RST_TX_ALARM;
		end else if (reg_wr_i) begin
			if (reg_addr_i == 8'h14) sh_sel <= reg_wdata_i & e1lc_pkg::USED_LINK_CTRL_SEL;
			if (reg_addr_i == 8'h15) sh_loop <= reg_wdata_i & e1lc_pkg::USED_CODING_LOOP;
			if (reg_addr_i == 8'h16) sh_alarm <= reg_wdata_i & e1lc_pkg::USED_TX_ALARM;
		end
	end
	always_comb begin
		case (reg_addr_i)
			8'h14: rd_exp = sh_sel;
			8'h15: rd_exp = sh_loop;
			8'h16: rd_exp = sh_alarm;
			default: rd_exp = 8'h00;
		endcase
	end
	assign data_bad = status_i.los | status_i.frame_sync_lost | status_i.crc4_sync_lost | status_i.rx_ais;
	assign sig_bad = status_i.multiframe_sync_lost | status_i.slot16_all_ones_detected;
	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (sys_rst_i);
	a_read_data: assert property ($past(reg_rd_i) |-> reg_rdata_o == $past(rd_exp))
		else $error("read data differs from stored word");
	a_read_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
		else $error("read data not zero outside read slot");
	a_nat_select: assert property (national_bit_sa_mask_o == ($past(sh_sel[7]) ? $past(sa_bits_sel_i) : 5'h00)
		&& national_bit_link_controller_sel_o == $past(sh_sel[7]))
		else $error("national bit controller select wrong");
	a_irq0_mask: assert property (national_bit_link_controller_sel_irq_o == ($past(national_bit_link_controller_sel_irq_i) && $past(sh_sel[7])))
		else $error("first controller interrupt not masked");
	a_irq1_mask: assert property (slot16_link_controller_sel_irq_o == ($past(slot16_link_controller_sel_irq_i) && $past(sh_sel[6])))
		else $error("second controller interrupt not masked");
	a_slot16_ccs: assert property (slot16_link_controller_sel_o == ($past(sh_sel[6]) && $past(ccs_mode_i)))
		else $error("slot 16 controller select wrong");
	a_rx_transparent: assert property (receive_transparent_o == $past(sh_sel[5]))
		else $error("receive transparent output wrong");
	a_ebit_value: assert property (tx_ebit_o ==
		($past(status_i.crc4_sync_lost) ? $past(sh_alarm[4]) : $past(crc4_compare_i)))
		else $error("transmit E-bit wrong");
	a_mf_reframe: assert property ($fell(sh_loop[4]) |-> ##[0:2] multiframe_reframe_o)
		else $error("no multiframe search pulse");
	a_basic_reframe: assert property ($fell(sh_alarm[3]) |-> ##[0:2] basic_frame_reframe_o)
		else $error("no frame search pulse");
	a_data_gate: assert property (backplane_data_out_oe_o == !($past(sh_alarm[1]) && $past(data_bad)))
		else $error("data output enable wrong");
	a_sig_gate: assert property (backplane_signalling_out_oe_o == !($past(sh_alarm[0]) && $past(sig_bad)))
		else $error("signalling output enable wrong");
endmodule : e1lc_path_ctrl_asserts

bind e1lc_path_ctrl e1lc_path_ctrl_asserts i_e1lc_path_ctrl_asserts (
	.core_clk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
	.status_i, .ccs_mode_i, .crc4_compare_i, .sa_bits_sel_i, .national_bit_link_controller_sel_irq_i, .slot16_link_controller_sel_irq_i,
	.backplane_data_out_oe_o, .backplane_signalling_out_oe_o, .national_bit_link_controller_sel_o,
	.national_bit_sa_mask_o, .slot16_link_controller_sel_o, .national_bit_link_controller_sel_irq_o, .slot16_link_controller_sel_irq_o,
	.receive_transparent_o, .tx_ebit_o, .multiframe_reframe_o, .basic_frame_reframe_o
);

// File: testbench/tb_e1lc_path_ctrl.sv
// Self-checking bench for the E1 link path control block
`timescale 1ns/1ps
module tb_e1lc_path_ctrl;
	// ****************************************
	// Signals and design
	// ****************************************
	logic core_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [7:0] reg_addr_i = 8'h00;
	logic [7:0] reg_wdata_i = 8'h00;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic line_rx_pos_i = 1'b0;
	logic line_rx_neg_i = 1'b0;
	logic backplane_data_in_i = 1'b0;
	logic framer_tx_bit_i = 1'b0;
	logic framer_rx_bit_i = 1'b0;
	logic framer_sig_bit_i = 1'b0;
	logic ccs_mode_i = 1'b0;
	logic crc4_compare_i = 1'b0;
	logic national_bit_link_controller_sel_irq_i = 1'b0;
	logic slot16_link_controller_sel_irq_i = 1'b0;
	logic [4:0] sa_bits_sel_i = 5'h00;
	e1lc_pkg::e1lc_status_s status_i = '0;
	logic [7:0] reg_rdata_o;
	logic [4:0] national_bit_sa_mask_o;
	logic line_tx_pos_o, line_tx_neg_o, backplane_data_out_o, backplane_data_out_oe_o;
	logic backplane_signalling_out_o, backplane_signalling_out_oe_o, bit_tick_o, rx_line_bit_o;
	logic national_bit_link_controller_sel_o, slot16_link_controller_sel_o, national_bit_link_controller_sel_irq_o;
	logic slot16_link_controller_sel_irq_o, receive_transparent_o, tx_ebit_o, multiframe_reframe_o;
	logic basic_frame_reframe_o, recovered_frame_or_clock_out_o;
	int num_errors = 0;
	int n_tests = 0;
	always #5 core_clk_i = ~core_clk_i;
	e1lc_path_ctrl i_e1lc_path_ctrl (
		.core_clk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
		.line_rx_pos_i, .line_rx_neg_i, .line_tx_pos_o, .line_tx_neg_o, .backplane_data_in_i,
		.backplane_data_out_o, .backplane_data_out_oe_o, .backplane_signalling_out_o,
		.backplane_signalling_out_oe_o, .framer_tx_bit_i, .framer_rx_bit_i, .framer_sig_bit_i,
		.status_i, .ccs_mode_i, .crc4_compare_i, .sa_bits_sel_i, .national_bit_link_controller_sel_irq_i, .slot16_link_controller_sel_irq_i,
		.bit_tick_o, .rx_line_bit_o, .national_bit_link_controller_sel_o, .national_bit_sa_mask_o,
		.slot16_link_controller_sel_o, .national_bit_link_controller_sel_irq_o, .slot16_link_controller_sel_irq_o, .receive_transparent_o,
		.tx_ebit_o, .multiframe_reframe_o, .basic_frame_reframe_o, .recovered_frame_or_clock_out_o
	);
	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge core_clk_i);
		reg_wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge core_clk_i);
		reg_rd_i <= 1'b0;
		#1 d = reg_rdata_o;
	endtask : rd
	// Waits for a bit tick, then moves to mid-bit
	task automatic bit_mid();
		int k;
		k = 0;
		do begin
			@(negedge core_clk_i);
			k++;
		end while (bit_tick_o !== 1'b1 && k < 200);
		repeat (20) @(negedge core_clk_i);
	endtask : bit_mid
	// Counts bits with a line mark, or with a decoded one when rx is set
	task automatic count_bits(input int n, input logic rx, output int cnt);
		cnt = 0;
		repeat (n) begin
			bit_mid();
			if ((rx ? rx_line_bit_o : (line_tx_pos_o | line_tx_neg_o)) === 1'b1) cnt++;
		end
	endtask : count_bits
	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : tally_and_finish
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_regs();
		logic [7:0] offs [4] = '{8'h14, 8'h15, 8'h16, 8'h17};
		logic [7:0] used [4] = '{e1lc_pkg::USED_LINK_CTRL_SEL, e1lc_pkg::USED_CODING_LOOP,
			e1lc_pkg::USED_TX_ALARM, 8'h00};
		logic [7:0] d;
		for (int i = 0; i < 4; i++) begin
			rd(offs[i], d);
			chk("word after reset", 8'h00, d);
			wr(offs[i], 8'hff);
			rd(offs[i], d);
			chk("word read back", used[i], d);
			wr(offs[i], 8'h00);
		end
	endtask : t_regs
	task automatic t_coding();
		int c;
		wr(8'h15, 8'h00);
		count_bits(8, 1'b0, c);
		count_bits(64, 1'b0, c);
		chk("marks for zeros, substituted", 32, c);
		wr(8'h15, 8'h20);
		count_bits(8, 1'b0, c);
		count_bits(64, 1'b0, c);
		chk("marks for zeros, plain", 0, c);
	endtask : t_coding
	task automatic t_alarm();
		logic [7:0] w [3] = '{8'h80, 8'h40, 8'h20};
		logic [7:0] lp [3] = '{8'h20, 8'h20, 8'h21};
		int n [3] = '{64, 256, 256};
		int e [3] = '{64, 8, 16};
		int c;
		for (int i = 0; i < 3; i++) begin
			wr(8'h15, lp[i]);
			framer_tx_bit_i <= lp[i][0];
			wr(8'h16, w[i]);
			count_bits(8, 1'b0, c);
			count_bits(n[i], 1'b0, c);
			chk("all-ones marks", e[i], c);
		end
		wr(8'h16, 8'h00);
		wr(8'h15, 8'h20);
		framer_tx_bit_i <= 1'b0;
	endtask : t_alarm
	task automatic t_rx_path();
		logic [7:0] w [5] = '{8'h20, 8'h28, 8'h60, 8'h08, 8'h40};
		logic tx [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
		int e [5] = '{0, 16, 16, 0, 0};
		int c;
		for (int i = 0; i < 5; i++) begin
			@(posedge core_clk_i);
			framer_tx_bit_i <= tx[i];
			wr(8'h15, w[i]);
			count_bits(8, 1'b1, c);
			count_bits(16, 1'b1, c);
			chk("decoded receive ones", e[i], c);
		end
		framer_tx_bit_i <= 1'b0;
	endtask : t_rx_path
	task automatic t_loops();
		for (int v = 0; v < 2; v++) begin
			wr(8'h15, 8'h26);
			line_rx_pos_i <= v[0];
			line_rx_neg_i <= !v[0];
			backplane_data_in_i <= v[0];
			bit_mid();
			bit_mid();
			chk("remote loop pos", v[0], line_tx_pos_o);
			chk("remote loop neg", !v[0], line_tx_neg_o);
			chk("backplane loop", v[0], backplane_data_out_o);
		end
		wr(8'h15, 8'h20);
		line_rx_neg_i <= 1'b0;
	endtask : t_loops
	task automatic t_rate(input logic fast, input int exp);
		int n;
		int r;
		int k;
		logic p;
		n = 0;
		r = 0;
		k = 0;
		wr(8'h16, {5'h00, fast, 2'b00});
		p = recovered_frame_or_clock_out_o;
		// First rise may come from the rate switch itself
		while (r < 3 && k < 50000) begin
			@(negedge core_clk_i);
			k++;
			if (r == 2 && bit_tick_o === 1'b1) n++;
			if (recovered_frame_or_clock_out_o === 1'b1 && p !== 1'b1) r++;
			p = recovered_frame_or_clock_out_o;
		end
		chk("recovered period in bits", exp, n);
	endtask : t_rate
	task automatic t_side();
		wr(8'h14, 8'h80);
		national_bit_link_controller_sel_irq_i <= 1'b1;
		slot16_link_controller_sel_irq_i <= 1'b1;
		ccs_mode_i <= 1'b1;
		sa_bits_sel_i <= 5'h15;
		crc4_compare_i <= 1'b0;
		framer_rx_bit_i <= 1'b1;
		framer_sig_bit_i <= 1'b1;
		wr(8'h16, 8'h13);
		status_i <= 6'b000001;
		repeat (3) @(posedge core_clk_i);
		#1 chk("second controller irq", 0, slot16_link_controller_sel_irq_o);
		chk("first controller irq on", 1, national_bit_link_controller_sel_irq_o);
		chk("national bit mask", 5'h15, national_bit_sa_mask_o);
		chk("signalling enable", 0, backplane_signalling_out_oe_o);
		chk("signalling data", 1, backplane_signalling_out_o);
		chk("data enable", 1, backplane_data_out_oe_o);
		chk("framed data out", 1, backplane_data_out_o);
		chk("E-bit in sync", 0, tx_ebit_o);
		@(posedge core_clk_i);
		status_i <= 6'b001000;
		repeat (3) @(posedge core_clk_i);
		#1 chk("data enable", 0, backplane_data_out_oe_o);
		chk("E-bit on lost sync", 1, tx_ebit_o);
		wr(8'h14, 8'h60);
		wr(8'h15, 8'h10);
		wr(8'h15, 8'h00);
		wr(8'h16, 8'h08);
		wr(8'h16, 8'h00);
		status_i <= '0;
		repeat (2) @(posedge core_clk_i);
		#1 chk("first controller irq", 0, national_bit_link_controller_sel_irq_o);
		chk("slot 16 controller", 1, slot16_link_controller_sel_o);
		chk("transparent data out", 0, backplane_data_out_o);
		chk("transparent flag", 1, receive_transparent_o);
	endtask : t_side
	// ****************************************
	// Main sequence and watchdog
	// ****************************************
	initial begin
		repeat (6) @(posedge core_clk_i);
		sys_rst_i <= 1'b0;
		t_regs();
		t_side();
		t_coding();
		t_alarm();
		t_rx_path();
		t_loops();
		t_rate(1'b1, 32);
		t_rate(1'b0, 256);
		tally_and_finish();
	end
	initial begin
		repeat (95000) @(posedge core_clk_i);
		num_errors++;
		tally_and_finish();
	end
endmodule : tb_e1lc_path_ctrl
